// >>> logic/tim34_pkg.sv
// Constants, field layouts and decode helpers for the channel 3/4 capture/compare block
package tim34_pkg;

    // Clock and trigger-to-output timing
    localparam int unsigned PCLK_HZ              = 50_000_000;
    localparam int unsigned FAST_TRIG_CYCLES     = 3;
    localparam int unsigned NORMAL_TRIG_CYCLES   = 5;

    // Register byte offsets on the APB
    localparam logic [11:0] MODE_OFS    = 12'h000;
    localparam logic [11:0] ENABLE_OFS  = 12'h004;
    localparam logic [11:0] CMP3_OFS    = 12'h008;
    localparam logic [11:0] CMP4_OFS    = 12'h00C;
    localparam logic [11:0] STATUS_OFS  = 12'h010;

    // Mode register: each channel owns one byte
    localparam int unsigned CH_FIELD_W  = 8;
    localparam int unsigned SEL_LSB     = 0;
    localparam int unsigned FAST_BIT    = 2;
    localparam int unsigned BUF_BIT     = 3;
    localparam int unsigned OCM_LSB     = 4;
    localparam int unsigned PSC_LSB     = 2;
    localparam int unsigned FILT_LSB    = 4;
    localparam logic [15:0] MODE_RESET  = 16'h0000;

    // Enable register: channel 3 at bits 9:8, channel 4 at bits 13:12
    localparam int unsigned EN_BASE     = 8;
    localparam int unsigned EN_STRIDE   = 4;
    localparam int unsigned POL_OFFSET  = 1;

    // Status register layout
    localparam int unsigned ST_REF_LSB  = 0;
    localparam int unsigned ST_FILT_LSB = 2;
    localparam int unsigned ST_OUT_LSB  = 4;

    // Direction select codes
    localparam logic [1:0] SEL_OUTPUT   = 2'h0;
    localparam logic [1:0] SEL_OWN_PIN  = 2'h1;
    localparam logic [1:0] SEL_PEER_PIN = 2'h2;
    localparam logic [1:0] SEL_TRIGGER  = 2'h3;

    // Compare mode codes
    localparam logic [2:0] OCM_FROZEN   = 3'h0;
    localparam logic [2:0] OCM_SET      = 3'h1;
    localparam logic [2:0] OCM_CLEAR    = 3'h2;
    localparam logic [2:0] OCM_TOGGLE   = 3'h3;
    localparam logic [2:0] OCM_FORCE_LO = 3'h4;
    localparam logic [2:0] OCM_FORCE_HI = 3'h5;
    localparam logic [2:0] OCM_PWM1     = 3'h6;
    localparam logic [2:0] OCM_PWM2     = 3'h7;

    typedef struct packed {
        logic [1:0] sel;
        logic [2:0] oc_mode;
        logic       buf_en;
        logic       fast_en;
        logic [3:0] filt;
        logic [1:0] psc;
    } chan_cfg_t;

    // Same byte carries either the output or the input layout
    function automatic chan_cfg_t decode_cfg(input logic [7:0] f);
        chan_cfg_t c;
        c.sel     = f[SEL_LSB +: 2];
        c.oc_mode = f[OCM_LSB +: 3];
        c.buf_en  = f[BUF_BIT];
        c.fast_en = f[FAST_BIT];
        c.filt    = f[FILT_LSB +: 4];
        c.psc     = f[PSC_LSB +: 2];
        return c;
    endfunction

    // Consecutive agreeing samples needed per filter code
    function automatic logic [3:0] filter_len(input logic [3:0] code);
        case (code)
            4'h0:                      filter_len = 4'h1;
            4'h1:                      filter_len = 4'h2;
            4'h2:                      filter_len = 4'h4;
            4'h3, 4'h5, 4'h7, 4'h9,
            4'hC, 4'hF:                filter_len = 4'h8;
            4'hA, 4'hD:                filter_len = 4'h5;
            default:                   filter_len = 4'h6;
        endcase
    endfunction

    // Mask on the free-running divider; sampling when masked bits are zero
    function automatic logic [4:0] filter_div_mask(input logic [3:0] code);
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3:    filter_div_mask = 5'h00;
            4'h4, 4'h5:                filter_div_mask = 5'h01;
            4'h6, 4'h7:                filter_div_mask = 5'h03;
            4'h8, 4'h9:                filter_div_mask = 5'h07;
            4'hA, 4'hB, 4'hC:          filter_div_mask = 5'h0F;
            default:                   filter_div_mask = 5'h1F;
        endcase
    endfunction

    // Events per capture for each prescaler code
    function automatic logic [2:0] capture_events(input logic [1:0] code);
        case (code)
            2'h0:    capture_events = 3'h1;
            2'h1:    capture_events = 3'h2;
            2'h2:    capture_events = 3'h4;
            default: capture_events = 3'h6;
        endcase
    endfunction

endpackage

// >>> logic/timer_ch34_capture_compare_mode.sv
// Capture/compare channels 3 and 4: mode control, fast trigger, input filter and capture prescaler
`timescale 1ns/1ns
module timer_ch34_capture_compare_mode #(
    parameter int unsigned CNT_W = 16
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Timer core
    input  wire logic [CNT_W-1:0] counter_value,
    input  wire logic             count_down,
    input  wire logic             update_event,
    input  wire logic             internal_trigger_in,
    // Input pins
    input  wire logic             timer_input_three,
    input  wire logic             timer_input_four,
    // Channel outputs
    output logic                  ch3_compare_output,
    output logic                  ch4_compare_output,
    output logic                  ch3_reference_level,
    output logic                  ch4_reference_level,
    output logic                  ch3_capture_strobe,
    output logic                  ch4_capture_strobe
);

    // Bus and control registers
    logic [15:0]          mode_r,    mode_nxt;
    logic [1:0]           en_r,      en_nxt;
    logic [1:0]           pol_r,     pol_nxt;
    logic [31:0]          prdata_r,  prdata_nxt;
    logic                 pready_r,  pready_nxt;
    logic                 pslverr_r, pslverr_nxt;

    // Channel state, index 0 is channel 3 and index 1 is channel 4
    logic [CNT_W-1:0]     cmp_act_r  [2];
    logic [CNT_W-1:0]     cmp_act_nxt[2];
    logic [CNT_W-1:0]     cmp_buf_r  [2];
    logic [CNT_W-1:0]     cmp_buf_nxt[2];
    logic [3:0]           fcnt_r     [2];
    logic [3:0]           fcnt_nxt   [2];
    logic [2:0]           pcnt_r     [2];
    logic [2:0]           pcnt_nxt   [2];
    logic [1:0]           ref_r,     ref_nxt;
    logic [1:0]           out_r,     out_nxt;
    logic [1:0]           match_r,   match_nxt;
    logic [1:0]           filt_r,    filt_nxt;
    logic [1:0]           lvl_r,     lvl_nxt;
    logic [1:0]           cap_r,     cap_nxt;
    logic [1:0]           fast1_r,   fast1_nxt;
    logic [1:0]           fast2_r,   fast2_nxt;
    logic                 trig_r,    trig_nxt;
    logic [4:0]           div_r,     div_nxt;

    // Pin synchronisers
    logic [1:0]           pin_s1_r, pin_s2_r, pin_s3_r;
    logic [1:0]           pin_lvl_r, pin_lvl_nxt;

    tim34_pkg::chan_cfg_t cfg [2];
    logic                 setup_ph;
    logic                 wr_acc;
    logic                 wr_cmp [2];

    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            cfg[c] = tim34_pkg::decode_cfg(mode_r[c*tim34_pkg::CH_FIELD_W +: tim34_pkg::CH_FIELD_W]);
        end
    end

    assign setup_ph  = psel & ~penable;
    assign wr_acc    = psel & penable & pwrite & pready_r;
    assign wr_cmp[0] = wr_acc & (paddr == tim34_pkg::CMP3_OFS);
    assign wr_cmp[1] = wr_acc & (paddr == tim34_pkg::CMP4_OFS);

    // Bus register group
    always_comb
    begin
        logic [15:0] wmode;
        wmode       = pwdata[15:0];
        mode_nxt    = mode_r;
        en_nxt      = en_r;
        pol_nxt     = pol_r;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        // Answer is prepared in the setup cycle so pready stands in the first access cycle
        pready_nxt  = setup_ph;
        if (setup_ph)
        begin
            prdata_nxt  = 32'h0000_0000;
            pslverr_nxt = 1'b0;
            case (paddr)
                tim34_pkg::MODE_OFS:   prdata_nxt[15:0] = mode_r;
                tim34_pkg::ENABLE_OFS:
                begin
                    for (int c = 0; c < 2; c++)
                    begin
                        prdata_nxt[tim34_pkg::EN_BASE + c*tim34_pkg::EN_STRIDE] = en_r[c];
                        prdata_nxt[tim34_pkg::EN_BASE + c*tim34_pkg::EN_STRIDE + tim34_pkg::POL_OFFSET] = pol_r[c];
                    end
                end
                tim34_pkg::CMP3_OFS:
                    prdata_nxt[CNT_W-1:0] = (cfg[0].sel == tim34_pkg::SEL_OUTPUT && cfg[0].buf_en)
                                            ? cmp_buf_r[0] : cmp_act_r[0];
                tim34_pkg::CMP4_OFS:
                    prdata_nxt[CNT_W-1:0] = (cfg[1].sel == tim34_pkg::SEL_OUTPUT && cfg[1].buf_en)
                                            ? cmp_buf_r[1] : cmp_act_r[1];
                tim34_pkg::STATUS_OFS:
                begin
                    prdata_nxt[tim34_pkg::ST_REF_LSB +: 2]  = ref_r;
                    prdata_nxt[tim34_pkg::ST_FILT_LSB +: 2] = filt_r;
                    prdata_nxt[tim34_pkg::ST_OUT_LSB +: 2]  = out_r;
                end
                default:               pslverr_nxt = 1'b1;
            endcase
        end
        if (wr_acc && paddr == tim34_pkg::MODE_OFS)
        begin
            mode_nxt = wmode;
            // Selection is frozen while the channel is enabled, so a live capture never changes source
            for (int c = 0; c < 2; c++)
            begin
                if (en_r[c])
                begin
                    mode_nxt[c*tim34_pkg::CH_FIELD_W + tim34_pkg::SEL_LSB +: 2] =
                        mode_r[c*tim34_pkg::CH_FIELD_W + tim34_pkg::SEL_LSB +: 2];
                end
            end
        end
        if (wr_acc && paddr == tim34_pkg::ENABLE_OFS)
        begin
            for (int c = 0; c < 2; c++)
            begin
                en_nxt[c]  = pwdata[tim34_pkg::EN_BASE + c*tim34_pkg::EN_STRIDE];
                pol_nxt[c] = pwdata[tim34_pkg::EN_BASE + c*tim34_pkg::EN_STRIDE + tim34_pkg::POL_OFFSET];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r    <= tim34_pkg::MODE_RESET;
            en_r      <= 2'h0;
            pol_r     <= 2'h0;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            mode_r    <= mode_nxt;
            en_r      <= en_nxt;
            pol_r     <= pol_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Pins: three flops, level accepted once the second and third agree
    always_comb
    begin
        pin_lvl_nxt = pin_lvl_r;
        for (int c = 0; c < 2; c++)
        begin
            if (pin_s2_r[c] == pin_s3_r[c])
            begin
                pin_lvl_nxt[c] = pin_s3_r[c];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_r  <= 2'h0;
            pin_s2_r  <= 2'h0;
            pin_s3_r  <= 2'h0;
            pin_lvl_r <= 2'h0;
        end
        else
        begin
            pin_s1_r  <= {timer_input_four, timer_input_three};
            pin_s2_r  <= pin_s1_r;
            pin_s3_r  <= pin_s2_r;
            pin_lvl_r <= pin_lvl_nxt;
        end
    end

    // Channel group
    always_comb
    begin
        logic trig_edge;
        logic is_pwm;
        logic hit;
        logic below;
        logic raw;
        logic samp;
        logic evt;
        trig_edge = internal_trigger_in & ~trig_r;
        is_pwm    = 1'b0;
        hit       = 1'b0;
        below     = 1'b0;
        raw       = 1'b0;
        samp      = 1'b0;
        evt       = 1'b0;
        trig_nxt  = internal_trigger_in;
        div_nxt   = div_r + 5'h01;
        ref_nxt   = ref_r;
        out_nxt   = out_r;
        match_nxt = match_r;
        filt_nxt  = filt_r;
        lvl_nxt   = lvl_r;
        cap_nxt   = 2'h0;
        fast1_nxt = 2'h0;
        fast2_nxt = fast1_r;
        for (int c = 0; c < 2; c++)
        begin
            cmp_act_nxt[c] = cmp_act_r[c];
            cmp_buf_nxt[c] = cmp_buf_r[c];
            fcnt_nxt[c]    = fcnt_r[c];
            pcnt_nxt[c]    = pcnt_r[c];
            if (cfg[c].sel == tim34_pkg::SEL_OUTPUT)
            begin
                is_pwm = (cfg[c].oc_mode == tim34_pkg::OCM_PWM1) || (cfg[c].oc_mode == tim34_pkg::OCM_PWM2);
                // Writes land in the buffer only while buffering, else in both copies
                if (wr_cmp[c])
                begin
                    cmp_buf_nxt[c] = pwdata[CNT_W-1:0];
                    if (!cfg[c].buf_en)
                    begin
                        cmp_act_nxt[c] = pwdata[CNT_W-1:0];
                    end
                end
                if (update_event && cfg[c].buf_en)
                begin
                    cmp_act_nxt[c] = cmp_buf_r[c];
                end
                hit          = (counter_value == cmp_act_r[c]);
                match_nxt[c] = hit;
                below        = count_down ? (counter_value <= cmp_act_r[c]) : (counter_value < cmp_act_r[c]);
                fast1_nxt[c] = trig_edge & cfg[c].fast_en & is_pwm;
                case (cfg[c].oc_mode)
                    tim34_pkg::OCM_FROZEN:   ref_nxt[c] = ref_r[c];
                    tim34_pkg::OCM_SET:      ref_nxt[c] = (hit & ~match_r[c]) ? 1'b1 : ref_r[c];
                    tim34_pkg::OCM_CLEAR:    ref_nxt[c] = (hit & ~match_r[c]) ? 1'b0 : ref_r[c];
                    tim34_pkg::OCM_TOGGLE:   ref_nxt[c] = (hit & ~match_r[c]) ? ~ref_r[c] : ref_r[c];
                    tim34_pkg::OCM_FORCE_LO: ref_nxt[c] = 1'b0;
                    tim34_pkg::OCM_FORCE_HI: ref_nxt[c] = 1'b1;
                    tim34_pkg::OCM_PWM1:     ref_nxt[c] = below;
                    tim34_pkg::OCM_PWM2:     ref_nxt[c] = ~below;
                    default:                 ref_nxt[c] = ref_r[c];
                endcase
                // Delayed trigger forces the level a match would give: inactive in PWM1, active in PWM2
                if (fast2_r[c] && cfg[c].fast_en && is_pwm)
                begin
                    ref_nxt[c] = (cfg[c].oc_mode == tim34_pkg::OCM_PWM2);
                end
                out_nxt[c] = en_r[c] & (ref_r[c] ^ pol_r[c]);
                fcnt_nxt[c] = 4'h0;
                pcnt_nxt[c] = 3'h0;
            end
            else
            begin
                out_nxt[c]   = 1'b0;
                match_nxt[c] = 1'b0;
                case (cfg[c].sel)
                    tim34_pkg::SEL_OWN_PIN:  raw = pin_lvl_r[c];
                    tim34_pkg::SEL_PEER_PIN: raw = pin_lvl_r[1-c];
                    tim34_pkg::SEL_TRIGGER:  raw = internal_trigger_in;
                    default:                 raw = 1'b0;
                endcase
                samp = ((div_r & tim34_pkg::filter_div_mask(cfg[c].filt)) == 5'h00);
                if (samp)
                begin
                    if (raw == filt_r[c])
                    begin
                        fcnt_nxt[c] = 4'h0;
                    end
                    else if (fcnt_r[c] + 4'h1 >= tim34_pkg::filter_len(cfg[c].filt))
                    begin
                        filt_nxt[c] = raw;
                        fcnt_nxt[c] = 4'h0;
                    end
                    else
                    begin
                        fcnt_nxt[c] = fcnt_r[c] + 4'h1;
                    end
                end
                lvl_nxt[c] = filt_r[c] ^ pol_r[c];
                evt        = lvl_nxt[c] & ~lvl_r[c];
                if (!en_r[c])
                begin
                    pcnt_nxt[c] = 3'h0;
                end
                else if (evt)
                begin
                    if (pcnt_r[c] + 3'h1 >= tim34_pkg::capture_events(cfg[c].psc))
                    begin
                        pcnt_nxt[c]    = 3'h0;
                        cap_nxt[c]     = 1'b1;
                        cmp_act_nxt[c] = counter_value;
                    end
                    else
                    begin
                        pcnt_nxt[c] = pcnt_r[c] + 3'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int c = 0; c < 2; c++)
            begin
                cmp_act_r[c] <= '0;
                cmp_buf_r[c] <= '0;
                fcnt_r[c]    <= 4'h0;
                pcnt_r[c]    <= 3'h0;
            end
            ref_r   <= 2'h0;
            out_r   <= 2'h0;
            match_r <= 2'h0;
            filt_r  <= 2'h0;
            lvl_r   <= 2'h0;
            cap_r   <= 2'h0;
            fast1_r <= 2'h0;
            fast2_r <= 2'h0;
            trig_r  <= 1'b0;
            div_r   <= 5'h00;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                cmp_act_r[c] <= cmp_act_nxt[c];
                cmp_buf_r[c] <= cmp_buf_nxt[c];
                fcnt_r[c]    <= fcnt_nxt[c];
                pcnt_r[c]    <= pcnt_nxt[c];
            end
            ref_r   <= ref_nxt;
            out_r   <= out_nxt;
            match_r <= match_nxt;
            filt_r  <= filt_nxt;
            lvl_r   <= lvl_nxt;
            cap_r   <= cap_nxt;
            fast1_r <= fast1_nxt;
            fast2_r <= fast2_nxt;
            trig_r  <= trig_nxt;
            div_r   <= div_nxt;
        end
    end

    assign prdata              = prdata_r;
    assign pready              = pready_r;
    assign pslverr             = pslverr_r;
    assign ch3_compare_output  = out_r[0];
    assign ch4_compare_output  = out_r[1];
    assign ch3_reference_level = ref_r[0];
    assign ch4_reference_level = ref_r[1];
    assign ch3_capture_strobe  = cap_r[0];
    assign ch4_capture_strobe  = cap_r[1];

endmodule

// >>> dv/tim34_pin_model.sv
// Model of the external timer input pins that feed the capture channels
`timescale 1ns/1ns
module tim34_pin_model (
    // Clock
    input  wire logic pclk,
    // Pins
    output logic      pin_three,
    output logic      pin_four
);
    initial
    begin
        pin_three = 1'b1;
        pin_four  = 1'b0;
    end

    // Pin three is the inverse of pin four, so both carry n rising edges per burst
    task automatic burst(input int n, input int w);
        repeat (n)
        begin
            @(posedge pclk);
            pin_four  <= 1'b1;
            pin_three <= 1'b0;
            repeat (w) @(posedge pclk);
            pin_four  <= 1'b0;
            pin_three <= 1'b1;
            repeat (w - 1) @(posedge pclk);
        end
    endtask
endmodule

// >>> dv/timer_ch34_capture_compare_mode_checker.sv
// Bus and strobe checker for the channel 3/4 capture/compare block
`timescale 1ns/1ns
module timer_ch34_capture_compare_mode_checker (
    // Watched ports
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ch3_capture_strobe,
    input wire logic        ch4_capture_strobe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no ready in first access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_needs_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pready && paddr[1:0] == 2'h0 && paddr <= 12'h010 |-> !pslverr)
        else $error("mapped access refused");
    a_rdata_holds: assert property (!pready && !(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside access");
    a_strobe3_pulse: assert property (ch3_capture_strobe |=> !ch3_capture_strobe)
        else $error("channel 3 strobe too long");
    a_strobe4_pulse: assert property (ch4_capture_strobe |=> !ch4_capture_strobe)
        else $error("channel 4 strobe too long");

    c_bus_error: cover property (pready && pslverr);
    c_capture3: cover property (ch3_capture_strobe);
    c_capture4: cover property (ch4_capture_strobe);
endmodule

bind timer_ch34_capture_compare_mode timer_ch34_capture_compare_mode_checker i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ch3_capture_strobe(ch3_capture_strobe),
    .ch4_capture_strobe(ch4_capture_strobe));

// >>> dv/timer_ch34_capture_compare_mode_tb_top.sv
// Self-checking bench for the channel 3/4 capture/compare block
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module timer_ch34_capture_compare_mode_tb_top;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic        upd     = 1'b0;
    logic        trig    = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin3;
    logic        pin4;
    logic [1:0]  ref_lvl;
    logic [1:0]  outs;
    logic [1:0]  stb;
    logic [31:0] rd;
    logic        err;
    int          n_fail      = 0;
    int          check_count = 0;
    int          cyc         = 0;
    int          n3          = 0;
    int          n4          = 0;
    int          b3;
    int          b4;
    int          cap[4]   = '{1, 2, 4, 6};
    int          fcode[7] = '{0, 3, 3, 4, 4, 15, 15};
    int          fw[7]    = '{3, 3, 12, 5, 20, 100, 300};
    int          fexp[7]  = '{4, 0, 4, 0, 4, 0, 4};
    logic [31:0] fm[3]    = '{32'h0000_6400, 32'h0000_6000, 32'h0000_5400};

    timer_ch34_capture_compare_mode i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .counter_value(16'h0010),
        .count_down(1'b0), .update_event(upd), .internal_trigger_in(trig), .timer_input_three(pin3),
        .timer_input_four(pin4), .ch3_compare_output(outs[0]), .ch4_compare_output(outs[1]),
        .ch3_reference_level(ref_lvl[0]), .ch4_reference_level(ref_lvl[1]),
        .ch3_capture_strobe(stb[0]), .ch4_capture_strobe(stb[1]));

    tim34_pin_model i_pins (.pclk(pclk), .pin_three(pin3), .pin_four(pin4));

    initial
    begin
        forever #10 pclk = ~pclk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        n3 += int'(stb[0]);
        n4 += int'(stb[1]);
        if (cyc == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end

    // Request is held from setup until ready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk(tim34_pkg::MODE_OFS, 32'h0000_0000);
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, tim34_pkg::MODE_OFS, {16'h0000, 6'h00, s[1:0], 6'h00, s[1:0]});
            rchk(tim34_pkg::MODE_OFS, {16'h0000, 6'h00, s[1:0], 6'h00, s[1:0]});
        end
        apb(1'b1, tim34_pkg::ENABLE_OFS, 32'h0000_1100);
        apb(1'b1, tim34_pkg::MODE_OFS, 32'h0000_0150);
        rchk(tim34_pkg::MODE_OFS, 32'h0000_0353);
        apb(1'b1, tim34_pkg::ENABLE_OFS, 32'h0000_0000);
        apb(1'b1, 12'h014, 32'hFFFF_FFFF);
        `CHK(err, 1'b1)
        rchk(12'h014, 32'h0000_0000);
        $display("register access test done");
        for (int m = 4; m < 6; m++)
            for (int c = 0; c < 2; c++)
            begin
                apb(1'b1, tim34_pkg::MODE_OFS, 32'(m << (4 + 8 * c)));
                repeat (3) @(posedge pclk);
                `CHK(ref_lvl[c], m[0])
                `CHK(outs, 2'b00)
            end
        $display("forced level test done");
        apb(1'b1, tim34_pkg::CMP4_OFS, 32'h0000_0100);
        apb(1'b1, tim34_pkg::ENABLE_OFS, 32'h0000_1000);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, tim34_pkg::MODE_OFS, fm[i]);
            repeat (3) @(posedge pclk);
            `CHK(outs[1], 1'b1)
            trig <= 1'b1;
            repeat (4) @(posedge pclk);
            `CHK(ref_lvl[1], (i != 0))
            trig <= 1'b0;
            @(posedge pclk);
            `CHK(ref_lvl[1], 1'b1)
        end
        $display("fast trigger test done");
        apb(1'b1, tim34_pkg::MODE_OFS, 32'h0000_6800);
        apb(1'b1, tim34_pkg::CMP4_OFS, 32'h0000_0005);
        rchk(tim34_pkg::CMP4_OFS, 32'h0000_0005);
        repeat (3) @(posedge pclk);
        `CHK(ref_lvl[1], 1'b1)
        upd <= 1'b1;
        @(posedge pclk);
        upd <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(ref_lvl[1], 1'b0)
        $display("buffered compare test done");
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b1, tim34_pkg::ENABLE_OFS, 32'h0000_0000);
            apb(1'b1, tim34_pkg::MODE_OFS, 32'((p << 10) | (p << 2)) | 32'h0000_0101);
            apb(1'b1, tim34_pkg::ENABLE_OFS, 32'h0000_1100);
            b3 = n3;
            b4 = n4;
            i_pins.burst(12, 3);
            repeat (12) @(posedge pclk);
            `CHK(n4 - b4, 12 / cap[p])
            `CHK(n3 - b3, 12 / cap[p])
        end
        $display("capture divider test done");
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, tim34_pkg::ENABLE_OFS, 32'h0000_0000);
            apb(1'b1, tim34_pkg::MODE_OFS, 32'(fcode[i] << 12) | 32'h0000_0200);
            apb(1'b1, tim34_pkg::ENABLE_OFS, 32'h0000_1000);
            b4 = n4;
            i_pins.burst(4, fw[i]);
            repeat (300) @(posedge pclk);
            `CHK(n4 - b4, fexp[i])
        end
        $display("input filter test done");
        // The trigger line is the source chosen for the channel before it is enabled
        apb(1'b1, tim34_pkg::ENABLE_OFS, 32'h0000_0000);
        apb(1'b1, tim34_pkg::MODE_OFS, 32'h0000_0300);
        apb(1'b1, tim34_pkg::ENABLE_OFS, 32'h0000_1000);
        b4 = n4;
        repeat (3)
        begin
            trig <= 1'b1;
            repeat (2) @(posedge pclk);
            trig <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
        `CHK(n4 - b4, 3)
        $display("trigger input test done");
        complete_run();
    end
endmodule
